// ---- verification/pllr_far_end.sv ----
// far side of the synthesizer: reference and oscillator sources and the two clock pin lines.
// assumes half periods of at least two system cycles; released pin lines are pulled up.
module pllr_far_end #(
   parameter int REF_HALF = 5,
   parameter int OSC_HALF = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_pos,
   input wire logic i_pos_oe_n,
   input wire logic i_neg,
   input wire logic i_neg_oe_n,
   output logic o_ref_clk,
   output logic o_osc_clk,
   output logic o_pos_pin,
   output logic o_neg_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int ref_cnt = 0;
   int osc_cnt = 0;
   logic ref_q = 1'b0;
   logic osc_q = 1'b0;
   assign o_ref_clk = ref_q;
   assign o_osc_clk = osc_q;
   // the behavioural loop stays at a fixed rate, so periods seen downstream are exact
   always @(posedge i_clk_sys) begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      if (ref_cnt == REF_HALF - 1) begin
         ref_q <= ~ref_q;
      end
      if (osc_cnt == OSC_HALF - 1) begin
         osc_q <= ~osc_q;
      end
   end
   // a released line falls to its pull-up instead of keeping the last value
   assign o_pos_pin = i_pos_oe_n ? 1'b1 : i_pos;
   assign o_neg_pin = i_neg_oe_n ? 1'b1 : i_neg;
endmodule

// ---- verification/pllr_top_tb.sv ----
// self-checking bench for the synthesizer counters and pin routing, driven over APB.
// assumes the far-end model supplies the input clocks and resolves the two clock pins.
module pllr_top_tb
   import pllr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic err;
   } pllr_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ref_clk;
   logic osc_clk;
   logic pos;
   logic pos_oe_n;
   logic neg;
   logic neg_oe_n;
   logic pos_pin;
   logic neg_pin;
   logic [4:0] global_clock_network;
   logic pfd_ref;
   logic pfd_fb;
   logic [6:0] watch;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int idx[6] = '{0, 1, 2, 4, 5, 6};
   int e_hi[6] = '{12, 6, 1536, 6, 1, 1};
   int e_per[6] = '{30, 12, 3072, 18, 20, 18};
   pllr_row_t rows[20] = '{
      '{1'b1, 8'h04, 32'h2, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h2, 1'b0},
      '{1'b1, 8'h08, 32'h3, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h3, 1'b0},
      '{1'b1, 8'h0C, 32'h30002, 32'h0, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h30002, 1'b0},
      '{1'b1, 8'h10, 32'h10001, 32'h0, 1'b0},
      '{1'b1, 8'h14, 32'h1000100, 32'h0, 1'b0},
      '{1'b1, 8'h18, 32'h100, 32'h0, 1'b0},
      '{1'b1, 8'h1C, 32'h101, 32'h0, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'h3DE, 1'b0},
      '{1'b1, 8'h1C, 32'h20001, 32'h0, 1'b0},
      '{1'b1, 8'h08, 32'h201, 32'h0, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'h37E, 1'b0},
      '{1'b1, 8'h08, 32'h3, 32'h0, 1'b0},
      '{1'b1, 8'h20, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h24, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h02, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h20, 32'h0, 32'h3FE, 1'b0}
   };

   always #50 clk = ~clk;
   assign watch = {pfd_fb, pfd_ref, global_clock_network};

   pllr_top u_pllr_top (
      .i_clk_sys(clk),
      .i_rst_n(rst_n),
      .i_psel(psel),
      .i_penable(penable),
      .i_pwrite(pwrite),
      .i_paddr(paddr),
      .i_pwdata(pwdata),
      .o_pready(pready),
      .o_pslverr(pslverr),
      .o_prdata(prdata),
      .i_ref_clk(ref_clk),
      .i_osc_clk(osc_clk),
      .i_ext_clock_out_pos(pos_pin),
      .i_ext_clock_out_neg(neg_pin),
      .o_ext_clock_out_pos(pos),
      .o_ext_clock_out_pos_oe_n(pos_oe_n),
      .o_ext_clock_out_neg(neg),
      .o_ext_clock_out_neg_oe_n(neg_oe_n),
      .o_global_clock_network(global_clock_network),
      .o_pfd_ref(pfd_ref),
      .o_pfd_fb(pfd_fb)
   );

   pllr_far_end u_pllr_far_end (
      .i_clk_sys(clk),
      .i_pos(pos),
      .i_pos_oe_n(pos_oe_n),
      .i_neg(neg),
      .i_neg_oe_n(neg_oe_n),
      .o_ref_clk(ref_clk),
      .o_osc_clk(osc_clk),
      .o_pos_pin(pos_pin),
      .o_neg_pin(neg_pin)
   );

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %0h seen %0h", s, e, g);
         errors++;
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic er);
      logic [31:0] rd;
      logic ge;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no cycle count is assumed; the bench timeout ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      ge = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk($sformatf("pready %0h", a), 32'h1, {31'h0, pready});
      chk($sformatf("pslverr %0h", a), {31'h0, er}, {31'h0, ge});
      if (!w && !er) begin
         chk($sformatf("prdata %0h", a), e, rd);
      end
   endtask

   // counts cycles while one watched line holds a level, bounded so a stuck line cannot hang
   task automatic cnt(input int k, input logic v, output int c);
      c = 0;
      while (watch[k] === v && c < 8000) begin
         @(posedge clk);
         c++;
      end
   endtask

   initial begin
      int hi;
      int lo;
      int bad;
      logic g;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].d, rows[i].e, rows[i].err);
      end
      $display("register table done");
      acc(1'b1, 8'h00, 32'h7, 32'h0, 1'b0);
      acc(1'b1, 8'h04, 32'h5, 32'h0, 1'b1);
      acc(1'b0, 8'h04, 32'h0, 32'h2, 1'b0);
      foreach (idx[i]) begin
         cnt(idx[i], 1'b1, hi);
         cnt(idx[i], 1'b0, lo);
         cnt(idx[i], 1'b1, hi);
         cnt(idx[i], 1'b0, lo);
         chk($sformatf("high time %0d", idx[i]), e_hi[i], hi);
         chk($sformatf("period %0d", idx[i]), e_per[i], hi + lo);
      end
      chk("global_clock_network 3 level", 32'h1, {31'h0, global_clock_network[3]});
      $display("divider periods done");
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, 8'h00, 32'h31 | 32'(m << 1), 32'h0, 1'b0);
         repeat (4) @(posedge clk);
         bad = 0;
         repeat (40) begin
            @(posedge clk);
            g = global_clock_network[0];
            if ({pos, pos_oe_n, neg, neg_oe_n} !== {m[0] & g, 1'b0, m == 2 ? g : m == 3 ? ~g : 1'b1, m < 2}) begin
               bad++;
            end
         end
         chk($sformatf("pin samples off mode %0d", m), 32'h0, bad);
      end
      $display("pin routing done");
      acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
      acc(1'b1, 8'h0C, 32'h101, 32'h0, 1'b0);
      acc(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
      acc(1'b1, 8'h04, 32'h5, 32'h0, 1'b0);
      acc(1'b0, 8'h04, 32'h0, 32'h5, 1'b0);
      acc(1'b1, 8'h0C, 32'h30002, 32'h0, 1'b0);
      acc(1'b1, 8'h00, 32'h7, 32'h0, 1'b0);
      $display("illegal run done");
      repeat (40) @(posedge clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("outputs in reset", 32'h5, {23'h0, global_clock_network, pos, pos_oe_n, neg, neg_oe_n} | {31'h0, pready});
      rst_n <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         acc(1'b0, 8'(4 * k), 32'h0, k == 0 ? 32'h0 : k < 3 ? 32'h1 : k < 8 ? 32'h10001 : 32'h3FE, 1'b0);
      end
      $display("reset values done");
      test_done();
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end
endmodule

// ---- verilog/pllr_div.sv ----
// one programmable counter: high count steps high, then low count steps low, wrap pulse per period.
// assumes i_step is a one-cycle pulse on the system clock and counts stay stable while enabled.
module pllr_div
   import pllr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic i_step,
   input wire logic [PLLR_CW-1:0] i_high,
   input wire logic [PLLR_CW-1:0] i_low,
   output logic o_clk,
   output logic o_wrap
);
   pllr_div_st_t s_reg;
   pllr_div_st_t s_next;
   logic [PLLR_PW-1:0] period;
   logic [PLLR_PW-1:0] cnt_inc;
   logic [PLLR_PW-1:0] seen_reg;

   assign period = PLLR_PW'(i_high) + PLLR_PW'(i_low);
   assign cnt_inc = PLLR_PW'(s_reg.cnt) + PLLR_PW'(1);

   always_comb begin
      s_next = s_reg;
      s_next.wrap = 1'b0;
      if (!i_en) begin
         s_next = '0;
      end else if (i_step) begin
         if (cnt_inc >= period) begin
            s_next.cnt = '0;
            s_next.wrap = 1'b1;
         end else begin
            s_next.cnt = cnt_inc[PLLR_CW-1:0];
         end
         // level shows where the counter sits within the period
         s_next.level = (PLLR_PW'(s_next.cnt) < PLLR_PW'(i_high));
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_clk = s_reg.level;
   assign o_wrap = s_reg.wrap;

   // step counter kept apart from the divider, only for checking
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen_reg <= '0;
      end else if (!i_en) begin
         seen_reg <= '0;
      end else if (s_reg.wrap) begin
         seen_reg <= i_step ? PLLR_PW'(1) : '0;
      end else if (i_step) begin
         seen_reg <= seen_reg + PLLR_PW'(1);
      end
   end

   property p_period;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_wrap && $past(i_en)) |-> (seen_reg == period);
   endproperty
   a_period: assert property (p_period) else $error("divider period differs from high plus low");
endmodule

// ---- verilog/pllr_pkg.sv ----
// constants, field layouts and state carriers for the clock synthesizer counters and output routing.
// assumes one 10 MHz system clock; reference and oscillator clocks arrive as asynchronous levels.
// Contract
// - only the first post divider may drive the dedicated external clock pins.
// - at most one external clock output: single-ended or one differential pair.
// - differential use drives the negative pin as complement of the positive pin.
// - single-ended use leaves the other pin free as ordinary user I/O.
// - with no external clock, both dedicated pins act as general-purpose I/O.
// - other post dividers reach pins only through the global clock network.
// - output frequency is reference times feedback count over pre-scale times post count.
// - exactly one pre-scale and one feedback counter, each programmable 1 to 512.
// - pre-scale divider only divides; it has no high/low duty setting.
// - five independent post dividers divide the oscillator clock for their own outputs.
// - an even duty post divider supports divide values up to 512.
// - an uneven duty post divider supports divide values only up to 256.
// - post divide value equals high count plus low count.
// - different outputs share one oscillator rate, each post divider dividing it down.
package pllr_pkg;
   localparam int PLLR_CW = 10;
   localparam int PLLR_PW = PLLR_CW + 1;
   localparam int PLLR_NPOST = 5;
   localparam int PLLR_AW = 8;
   localparam int PLLR_DW = 32;
   localparam int PLLR_NSYNC = 4;
   localparam logic [PLLR_PW-1:0] PLLR_MAX_EVEN = 11'h200;
   localparam logic [PLLR_PW-1:0] PLLR_MAX_ODD = 11'h100;
   localparam logic [PLLR_PW-1:0] PLLR_MAX_MN = 11'h200;

   // register byte addresses
   localparam logic [PLLR_AW-1:0] PLLR_A_CTRL = 8'h00;
   localparam logic [PLLR_AW-1:0] PLLR_A_PRE = 8'h04;
   localparam logic [PLLR_AW-1:0] PLLR_A_FB = 8'h08;
   localparam logic [PLLR_AW-1:0] PLLR_A_POST0 = 8'h0C;
   localparam logic [PLLR_AW-1:0] PLLR_A_STAT = 8'h20;

   // control fields
   localparam int PLLR_C_RUN = 0;
   localparam int PLLR_C_MODE = 1;
   localparam int PLLR_C_GOUT = 3;
   localparam int PLLR_C_GOE = 5;
   localparam int PLLR_C_W = 7;
   localparam logic [PLLR_C_W-1:0] PLLR_CTRL_RST = 7'h00;
   localparam int PLLR_P_LO = 16;
   localparam logic [PLLR_CW-1:0] PLLR_CNT_RST = 10'h001;

   // status fields
   localparam int PLLR_S_RUN = 0;
   localparam int PLLR_S_POK = 1;
   localparam int PLLR_S_NOK = 6;
   localparam int PLLR_S_MOK = 7;
   localparam int PLLR_S_PIN = 8;
   localparam int PLLR_S_GLOBAL_CLOCK_NETWORK = 10;

   // sync bit positions
   localparam int PLLR_Y_REF = 0;
   localparam int PLLR_Y_OSC = 1;
   localparam int PLLR_Y_PPOS = 2;
   localparam int PLLR_Y_PNEG = 3;

   typedef enum logic [1:0] {
      PLLR_EXT_GPIO = 2'h0,
      PLLR_EXT_SE_POS = 2'h1,
      PLLR_EXT_SE_NEG = 2'h2,
      PLLR_EXT_DIFF = 2'h3
   } pllr_ext_mode_t;

   typedef enum logic [1:0] {
      PLLR_ST_IDLE = 2'b01,
      PLLR_ST_RUN = 2'b10
   } pllr_fsm_t;

   typedef struct packed {
      logic [PLLR_CW-1:0] cnt;
      logic level;
      logic wrap;
   } pllr_div_st_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [PLLR_AW-1:0] paddr;
      logic [PLLR_DW-1:0] pwdata;
   } pllr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [PLLR_DW-1:0] prdata;
   } pllr_apb_rsp_t;

   typedef struct packed {
      logic pos;
      logic neg;
      logic pos_oe_n;
      logic neg_oe_n;
   } pllr_pins_t;

   typedef struct packed {
      logic [PLLR_NSYNC-1:0] sync1;
      logic [PLLR_NSYNC-1:0] sync2;
      logic [1:0] prev;
      pllr_fsm_t fsm;
      logic [PLLR_C_W-1:0] ctrl;
      logic [PLLR_CW-1:0] pre;
      logic [PLLR_CW-1:0] fb;
      logic [PLLR_NPOST-1:0][PLLR_CW-1:0] hi;
      logic [PLLR_NPOST-1:0][PLLR_CW-1:0] lo;
      pllr_apb_rsp_t rsp;
      pllr_pins_t pins;
      logic [PLLR_NPOST-1:0] global_clock_network;
      logic pfd_ref;
      logic pfd_fb;
   } pllr_state_t;
endpackage

// ---- verilog/pllr_top.sv ----
// counters and output routing of the clock synthesizer, with an APB register slave.
// assumes reference and oscillator clocks are far slower than i_clk_sys and arrive asynchronously.
//
// Our own choices: the register addresses and the APB interface to the registers.
module pllr_top
   import pllr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PLLR_AW-1:0] i_paddr,
   input wire logic [PLLR_DW-1:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [PLLR_DW-1:0] o_prdata,
   input wire logic i_ref_clk,
   input wire logic i_osc_clk,
   input wire logic i_ext_clock_out_pos,
   input wire logic i_ext_clock_out_neg,
   output logic o_ext_clock_out_pos,
   output logic o_ext_clock_out_pos_oe_n,
   output logic o_ext_clock_out_neg,
   output logic o_ext_clock_out_neg_oe_n,
   output logic [PLLR_NPOST-1:0] o_global_clock_network,
   output logic o_pfd_ref,
   output logic o_pfd_fb
);
   pllr_state_t s_reg;
   pllr_state_t s_next;
   pllr_apb_req_t req;
   logic ref_rise;
   logic osc_rise;
   logic run_en;
   logic pre_wrap;
   logic fb_wrap;
   logic [PLLR_NPOST-1:0] post_clk;
   logic [PLLR_NPOST-1:0] post_ok;
   logic pre_ok;
   logic fb_ok;
   logic all_ok;
   pllr_ext_mode_t mode;
   logic [1:0] gpio_out;
   logic [1:0] gpio_oe;

   assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};

   // edges are taken from the second stage against a third, never from the first
   assign ref_rise = s_reg.sync2[PLLR_Y_REF] & ~s_reg.prev[0];
   assign osc_rise = s_reg.sync2[PLLR_Y_OSC] & ~s_reg.prev[1];
   assign run_en = (s_reg.fsm == PLLR_ST_RUN);
   assign mode = pllr_ext_mode_t'(s_reg.ctrl[PLLR_C_MODE +: 2]);
   assign gpio_out = s_reg.ctrl[PLLR_C_GOUT +: 2];
   assign gpio_oe = s_reg.ctrl[PLLR_C_GOE +: 2];

   function automatic logic cnt_ok(input logic [PLLR_CW-1:0] c);
      cnt_ok = (c != '0) && (PLLR_PW'(c) <= PLLR_MAX_MN);
   endfunction

   // even duty allows the long range, any other split the short one
   function automatic logic post_range_ok(input logic [PLLR_CW-1:0] h, input logic [PLLR_CW-1:0] l);
      logic [PLLR_PW-1:0] sum;
      sum = PLLR_PW'(h) + PLLR_PW'(l);
      if (sum == '0) begin
         post_range_ok = 1'b0;
      end else if (h == l) begin
         post_range_ok = (sum <= PLLR_MAX_EVEN);
      end else begin
         post_range_ok = (sum <= PLLR_MAX_ODD);
      end
   endfunction

   assign pre_ok = cnt_ok(s_reg.pre);
   assign fb_ok = cnt_ok(s_reg.fb);

   // pre-scale divides the reference; its level output is unused, only the wrap matters
   pllr_div u_pre (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_en(run_en),
      .i_step(ref_rise),
      .i_high(s_reg.pre),
      .i_low('0),
      .o_clk(),
      .o_wrap(pre_wrap)
   );

   pllr_div u_fb (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_en(run_en),
      .i_step(osc_rise),
      .i_high(s_reg.fb),
      .i_low('0),
      .o_clk(),
      .o_wrap(fb_wrap)
   );

   // all post dividers count the same oscillator edges
   for (genvar k = 0; k < PLLR_NPOST; k++) begin : g_post
      assign post_ok[k] = post_range_ok(s_reg.hi[k], s_reg.lo[k]);
      pllr_div u_post (
         .i_clk_sys(i_clk_sys),
         .i_rst_n(i_rst_n),
         .i_en(run_en),
         .i_step(osc_rise),
         .i_high(s_reg.hi[k]),
         .i_low(s_reg.lo[k]),
         .o_clk(post_clk[k]),
         .o_wrap()
      );
   end

   assign all_ok = pre_ok & fb_ok & (&post_ok);

   always_comb begin
      logic acc;
      logic hit;
      logic busy_wr;
      logic [PLLR_AW-1:0] off;
      logic [PLLR_AW-3:0] pidx;
      logic [PLLR_DW-1:0] rd;
      acc = 1'b0;
      hit = 1'b0;
      busy_wr = 1'b0;
      off = '0;
      pidx = '0;
      rd = '0;
      s_next = s_reg;

      s_next.sync1 = {i_ext_clock_out_neg, i_ext_clock_out_pos, i_osc_clk, i_ref_clk};
      s_next.sync2 = s_reg.sync1;
      s_next.prev = {s_reg.sync2[PLLR_Y_OSC], s_reg.sync2[PLLR_Y_REF]};

      // loop runs only on a complete, legal set of counts
      case (s_reg.fsm)
         PLLR_ST_IDLE: begin
            if (s_reg.ctrl[PLLR_C_RUN] && all_ok) begin
               s_next.fsm = PLLR_ST_RUN;
            end
         end
         PLLR_ST_RUN: begin
            if (!s_reg.ctrl[PLLR_C_RUN]) begin
               s_next.fsm = PLLR_ST_IDLE;
            end
         end
         default: begin
            s_next.fsm = PLLR_ST_IDLE;
         end
      endcase

      // apb: one wait cycle, answer registered
      acc = req.psel & req.penable;
      off = req.paddr - PLLR_A_POST0;
      pidx = off[PLLR_AW-1:2];
      if (req.paddr[1:0] == 2'h0) begin
         if (req.paddr == PLLR_A_CTRL) begin
            hit = 1'b1;
            rd = PLLR_DW'(s_reg.ctrl);
         end else if (req.paddr == PLLR_A_PRE) begin
            hit = 1'b1;
            rd = PLLR_DW'(s_reg.pre);
         end else if (req.paddr == PLLR_A_FB) begin
            hit = 1'b1;
            rd = PLLR_DW'(s_reg.fb);
         end else if (req.paddr >= PLLR_A_POST0 && req.paddr < PLLR_A_STAT) begin
            hit = 1'b1;
            rd = PLLR_DW'(s_reg.hi[pidx]);
            rd[PLLR_P_LO +: PLLR_CW] = s_reg.lo[pidx];
         end else if (req.paddr == PLLR_A_STAT) begin
            hit = 1'b1;
            rd[PLLR_S_RUN] = run_en;
            rd[PLLR_S_POK +: PLLR_NPOST] = post_ok;
            rd[PLLR_S_NOK] = pre_ok;
            rd[PLLR_S_MOK] = fb_ok;
            rd[PLLR_S_PIN +: 2] = s_reg.sync2[PLLR_Y_PPOS +: 2];
            rd[PLLR_S_GLOBAL_CLOCK_NETWORK +: PLLR_NPOST] = s_reg.global_clock_network;
         end
      end
      // counts are frozen while running so the outputs never glitch
      busy_wr = req.pwrite && run_en && hit && (req.paddr != PLLR_A_CTRL) && (req.paddr != PLLR_A_STAT);

      s_next.rsp.pready = acc & ~s_reg.rsp.pready;
      if (acc && !s_reg.rsp.pready) begin
         s_next.rsp.pslverr = ~hit | busy_wr | (req.pwrite & (req.paddr == PLLR_A_STAT));
         s_next.rsp.prdata = req.pwrite ? '0 : rd;
      end else if (!acc) begin
         s_next.rsp.pslverr = 1'b0;
         s_next.rsp.prdata = '0;
      end

      if (acc && s_reg.rsp.pready && req.pwrite && !s_reg.rsp.pslverr) begin
         if (req.paddr == PLLR_A_CTRL) begin
            s_next.ctrl = req.pwdata[PLLR_C_W-1:0];
         end else if (req.paddr == PLLR_A_PRE) begin
            s_next.pre = req.pwdata[PLLR_CW-1:0];
         end else if (req.paddr == PLLR_A_FB) begin
            s_next.fb = req.pwdata[PLLR_CW-1:0];
         end else if (req.paddr >= PLLR_A_POST0 && req.paddr < PLLR_A_STAT) begin
            s_next.hi[pidx] = req.pwdata[PLLR_CW-1:0];
            s_next.lo[pidx] = req.pwdata[PLLR_P_LO +: PLLR_CW];
         end
      end

      // only the first post divider has a path to the dedicated pins
      s_next.pins.pos = gpio_out[0];
      s_next.pins.neg = gpio_out[1];
      s_next.pins.pos_oe_n = ~gpio_oe[0];
      s_next.pins.neg_oe_n = ~gpio_oe[1];
      case (mode)
         PLLR_EXT_GPIO: begin
            s_next.pins.pos = gpio_out[0];
         end
         PLLR_EXT_SE_POS: begin
            s_next.pins.pos = post_clk[0];
            s_next.pins.pos_oe_n = 1'b0;
         end
         PLLR_EXT_SE_NEG: begin
            s_next.pins.neg = post_clk[0];
            s_next.pins.neg_oe_n = 1'b0;
         end
         PLLR_EXT_DIFF: begin
            s_next.pins.pos = post_clk[0];
            s_next.pins.neg = ~post_clk[0];
            s_next.pins.pos_oe_n = 1'b0;
            s_next.pins.neg_oe_n = 1'b0;
         end
         default: begin
            s_next.pins.pos = gpio_out[0];
         end
      endcase

      s_next.global_clock_network = post_clk;
      s_next.pfd_ref = pre_wrap;
      s_next.pfd_fb = fb_wrap;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
         s_reg.fsm <= PLLR_ST_IDLE;
         s_reg.ctrl <= PLLR_CTRL_RST;
         s_reg.pre <= PLLR_CNT_RST;
         s_reg.fb <= PLLR_CNT_RST;
         s_reg.hi <= {PLLR_NPOST{PLLR_CNT_RST}};
         s_reg.lo <= {PLLR_NPOST{PLLR_CNT_RST}};
         s_reg.pins.pos_oe_n <= 1'b1;
         s_reg.pins.neg_oe_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_pready = s_reg.rsp.pready;
   assign o_pslverr = s_reg.rsp.pslverr;
   assign o_prdata = s_reg.rsp.prdata;
   assign o_ext_clock_out_pos = s_reg.pins.pos;
   assign o_ext_clock_out_neg = s_reg.pins.neg;
   assign o_ext_clock_out_pos_oe_n = s_reg.pins.pos_oe_n;
   assign o_ext_clock_out_neg_oe_n = s_reg.pins.neg_oe_n;
   assign o_global_clock_network = s_reg.global_clock_network;
   assign o_pfd_ref = s_reg.pfd_ref;
   assign o_pfd_fb = s_reg.pfd_fb;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   property p_diff;
      $past(mode) == PLLR_EXT_DIFF |-> (o_ext_clock_out_neg == ~o_ext_clock_out_pos) &&
         !o_ext_clock_out_pos_oe_n && !o_ext_clock_out_neg_oe_n;
   endproperty
   a_diff: assert property (p_diff) else $error("differential pins not complementary");

   property p_se_pos;
      $past(mode) == PLLR_EXT_SE_POS |-> (o_ext_clock_out_pos == $past(post_clk[0])) &&
         (o_ext_clock_out_neg == $past(gpio_out[1])) && (o_ext_clock_out_neg_oe_n == $past(~gpio_oe[1]));
   endproperty
   a_se_pos: assert property (p_se_pos) else $error("single-ended routing wrong");

   property p_se_neg;
      $past(mode) == PLLR_EXT_SE_NEG |-> (o_ext_clock_out_neg == $past(post_clk[0])) &&
         (o_ext_clock_out_pos == $past(gpio_out[0]));
   endproperty
   a_se_neg: assert property (p_se_neg) else $error("external pin not fed by first divider");

   property p_gpio;
      $past(mode) == PLLR_EXT_GPIO |-> ({o_ext_clock_out_neg, o_ext_clock_out_pos} == $past(gpio_out)) &&
         ({o_ext_clock_out_neg_oe_n, o_ext_clock_out_pos_oe_n} == $past(~gpio_oe));
   endproperty
   a_gpio: assert property (p_gpio) else $error("pins not under gpio control");

   property p_global_clock_network;
      ##1 o_global_clock_network == $past(post_clk);
   endproperty
   a_global_clock_network: assert property (p_global_clock_network) else $error("global clock does not follow its divider");

   property p_run_ok;
      run_en |-> (&post_ok) && pre_ok && fb_ok;
   endproperty
   a_run_ok: assert property (p_run_ok) else $error("running with an illegal count");

   property p_range;
      (s_reg.hi[0] != s_reg.lo[0]) && (PLLR_PW'(s_reg.hi[0]) + PLLR_PW'(s_reg.lo[0]) > PLLR_MAX_ODD) |->
         !post_ok[0];
   endproperty
   a_range: assert property (p_range) else $error("uneven divide above limit accepted");

   property p_apb;
      (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer not one cycle after access");

   property p_frozen;
      run_en && $past(run_en) |-> $stable(s_reg.pre) && $stable(s_reg.fb) && $stable(s_reg.hi);
   endproperty
   a_frozen: assert property (p_frozen) else $error("counts changed while running");
endmodule
